// ### hw/uiec_top.sv
// low IN endpoint control and status logic, APB slave
`timescale 1ns/1ns
`include "uiec_consts.svh"
module uiec_top (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic [31:0]               prdata,
   input  wire uiec_pkg::uiec_link_s link_i,
   output uiec_pkg::uiec_resp_s      resp_o,
   output logic [2:0]                ep_event
);
   // -----------------------------------------
   // state
   // -----------------------------------------
   uiec_pkg::uiec_state_s st_r;
   uiec_pkg::uiec_state_s st_nxt;

   function automatic logic [1:0] ep_slot(input logic [1:0] e);
      ep_slot = e - 2'h1;
   endfunction

   function automatic uiec_pkg::uiec_ep_s pop(input uiec_pkg::uiec_ep_s e);
      uiec_pkg::uiec_ep_s r;
      r = e;
      r.zlp = {1'b0, e.zlp[1]};
      r.cnt = e.cnt - 2'h1;
      r.loaded = 1'b0;
      pop = r;
   endfunction

   logic [7:0]  word_idx;
   logic        map_hit;
   logic        sel_ok;
   logic [1:0]  sel;
   logic        wr_take;
   logic [31:0] rd_word;

   assign word_idx = {2'h0, paddr[7:2]};
   assign map_hit  = paddr[1:0] == 2'h0 &&
                     (word_idx == `UIEC_IDX_INDEX || word_idx == `UIEC_IDX_CTRL_LO ||
                      word_idx == `UIEC_IDX_CTRL_HI);
   assign sel_ok   = st_r.index != 2'h0;
   assign sel      = ep_slot(st_r.index);
   assign wr_take  = psel & penable & st_r.pready & pwrite & map_hit;

   // -----------------------------------------
   // read mux
   // -----------------------------------------
   always_comb begin
      rd_word = 32'h0;
      if (word_idx == `UIEC_IDX_INDEX) begin
         rd_word[1:0] = st_r.index;
      end else if (sel_ok && word_idx == `UIEC_IDX_CTRL_LO) begin
         // top bit and toggle_clear stay zero
         rd_word[`UIEC_LO_STSENT]   = st_r.ep[sel].stall_sent;
         rd_word[`UIEC_LO_FSTALL]   = st_r.ep[sel].force_stall;
         rd_word[`UIEC_LO_UNDERRUN_FLAG]   = st_r.ep[sel].underrun;
         rd_word[`UIEC_LO_NONEMPTY] = st_r.ep[sel].cnt != 2'h0;
         // a deferred packet is hidden until frame start
         rd_word[`UIEC_LO_LOADED]   = st_r.ep[sel].loaded & ~st_r.ep[sel].held;
      end else if (sel_ok && word_idx == `UIEC_IDX_CTRL_HI) begin
         rd_word[`UIEC_HI_DBUF]  = st_r.ep[sel].double_buffer_on;
         rd_word[`UIEC_HI_ISO]   = st_r.ep[sel].iso;
         rd_word[`UIEC_HI_ISO_DEFERRED_UPDATE] = st_r.ep[sel].iso_deferred_update;
      end
   end

   // -----------------------------------------
   // next state
   // -----------------------------------------
   always_comb begin
      uiec_pkg::uiec_ep_s w;
      logic [1:0]         te;
      st_nxt = st_r;
      w = st_r.ep[sel];
      te = ep_slot(link_i.token_ep);
      // frame start frees held packets; a load in the same cycle still waits
      if (link_i.sof) begin
         for (int i = 0; i < 3; i++) begin
            st_nxt.ep[i].held = 1'b0;
         end
         w = st_nxt.ep[sel];
      end
      st_nxt.resp.valid = 1'b0;
      st_nxt.irq = 3'h0;
      // zero-wait slave: answer is ready in the access cycle
      st_nxt.pready = psel & ~penable;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h0;
      if (psel & ~penable) begin
         st_nxt.pslverr = ~map_hit;
         st_nxt.prdata = pwrite ? 32'h0 : rd_word;
      end

      // register writes go first so that hardware sets below win
      if (wr_take && word_idx == `UIEC_IDX_INDEX) begin
         st_nxt.index = pwdata[1:0];
      end
      if (wr_take && sel_ok && word_idx == `UIEC_IDX_CTRL_HI) begin
         w.double_buffer_on = pwdata[`UIEC_HI_DBUF];
         w.iso   = pwdata[`UIEC_HI_ISO];
         w.iso_deferred_update = pwdata[`UIEC_HI_ISO_DEFERRED_UPDATE];
         st_nxt.ep[sel] = w;
      end
      if (wr_take && sel_ok && word_idx == `UIEC_IDX_CTRL_LO) begin
         if (pwdata[`UIEC_LO_TOGCLR]) begin
            w.toggle = 1'b0;
         end
         if (!pwdata[`UIEC_LO_STSENT]) begin
            w.stall_sent = 1'b0;
         end
         w.force_stall = pwdata[`UIEC_LO_FSTALL];
         if (!pwdata[`UIEC_LO_UNDERRUN_FLAG]) begin
            w.underrun = 1'b0;
         end
         // one packet per flush write, oldest first
         if (pwdata[`UIEC_LO_FLUSH] && w.cnt != 2'h0) begin
            w = pop(w);
            w.held = 1'b0;
            st_nxt.irq[sel] = 1'b1;
         end
         // single buffer refuses a second packet while one is queued
         if (pwdata[`UIEC_LO_LOADED] && w.cnt != `UIEC_SLOTS &&
             (w.double_buffer_on || w.cnt == 2'h0)) begin
            if (w.cnt == 2'h0) begin
               w.zlp[0] = ~w.data_seen;
            end else begin
               w.zlp[1] = ~w.data_seen;
            end
            w.cnt = w.cnt + 2'h1;
            w.data_seen = 1'b0;
            // free slot left: release at once, no event
            w.loaded = ~(w.double_buffer_on && w.cnt != `UIEC_SLOTS);
            w.held = w.iso & w.iso_deferred_update;
         end
         st_nxt.ep[sel] = w;
      end

      if (link_i.fifo_wr && link_i.fifo_wr_ep != 2'h0) begin
         st_nxt.ep[ep_slot(link_i.fifo_wr_ep)].data_seen = 1'b1;
      end

      // -----------------------------------------
      // IN token handshake
      // -----------------------------------------
      if (link_i.in_token && link_i.token_ep != 2'h0) begin
         st_nxt.resp.valid = 1'b1;
         st_nxt.resp.ep = link_i.token_ep;
         st_nxt.resp.toggle = st_nxt.ep[te].toggle;
         if (st_nxt.ep[te].force_stall) begin
            st_nxt.resp.kind = uiec_pkg::RK_STALL;
            st_nxt.ep[te].stall_sent = 1'b1;
            st_nxt.irq[te] = 1'b1;
         end else if (st_nxt.ep[te].cnt != 2'h0 && !st_nxt.ep[te].held) begin
            st_nxt.resp.kind = st_nxt.ep[te].zlp[0] ? uiec_pkg::RK_ZLP
                                                    : uiec_pkg::RK_DATA;
         end else if (st_nxt.ep[te].iso) begin
            st_nxt.resp.kind = uiec_pkg::RK_ZLP;
            st_nxt.ep[te].underrun = 1'b1;
         end else begin
            st_nxt.resp.kind = uiec_pkg::RK_NAK;
            st_nxt.ep[te].underrun = 1'b1;
         end
      end

      // completion of a data packet named by token_ep
      if (link_i.tx_done && link_i.token_ep != 2'h0 &&
          st_nxt.ep[te].cnt != 2'h0 && !st_nxt.ep[te].held) begin
         st_nxt.ep[te] = pop(st_nxt.ep[te]);
         st_nxt.irq[te] = 1'b1;
         if (link_i.tx_acked) begin
            st_nxt.ep[te].toggle = ~st_r.ep[te].toggle;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pready   = st_r.pready;
   assign pslverr  = st_r.pslverr;
   assign prdata   = st_r.prdata;
   assign resp_o   = st_r.resp;
   assign ep_event = st_r.irq;

   // -----------------------------------------
   // checks
   // -----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic wr_lo;
   logic rd_lo;
   logic tok_ok;
   logic sel_nonempty;
   logic [1:0] te_q;
   assign wr_lo  = wr_take && sel_ok && word_idx == `UIEC_IDX_CTRL_LO;
   assign rd_lo  = psel && !penable && !pwrite && sel_ok && word_idx == `UIEC_IDX_CTRL_LO;
   assign tok_ok = link_i.in_token && link_i.token_ep != 2'h0 && !wr_take;
   assign sel_nonempty = st_r.ep[sel].cnt != 2'h0;

   a_toggle_cleared: assert property (
      wr_lo && pwdata[`UIEC_LO_TOGCLR] && !link_i.tx_done |=> st_r.ep[$past(sel)].toggle == 1'b0)
      else $error("toggle not cleared");

   a_lo_top_zero: assert property (
      $past(rd_lo) |-> st_r.prdata[7:6] == 2'h0)
      else $error("reserved or toggle_clear bit read as one");

   a_stall_answer: assert property (
      tok_ok && st_r.ep[ep_slot(link_i.token_ep)].force_stall
      |=> st_r.resp.valid && st_r.resp.kind == uiec_pkg::RK_STALL && st_r.ep[te_q].stall_sent)
      else $error("forced stall not answered");

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         te_q <= 2'h0;
      end else begin
         te_q <= ep_slot(link_i.token_ep);
      end
   end

   a_stall_sent_set: assert property (
      st_r.resp.valid && st_r.resp.kind == uiec_pkg::RK_STALL |-> st_r.ep[te_q].stall_sent)
      else $error("stall sent flag missing");

   a_resume_normal: assert property (
      tok_ok && !st_r.ep[ep_slot(link_i.token_ep)].force_stall
      |=> st_r.resp.kind != uiec_pkg::RK_STALL)
      else $error("stall after force_stall cleared");

   a_iso_underrun: assert property (
      tok_ok && !st_r.ep[ep_slot(link_i.token_ep)].force_stall &&
      st_r.ep[ep_slot(link_i.token_ep)].iso && st_r.ep[ep_slot(link_i.token_ep)].cnt == 2'h0
      |=> st_r.resp.kind == uiec_pkg::RK_ZLP && st_r.ep[te_q].underrun)
      else $error("iso underrun not flagged");

   a_nak_underrun: assert property (
      st_r.resp.valid && st_r.resp.kind == uiec_pkg::RK_NAK |-> st_r.ep[te_q].underrun)
      else $error("nak without underrun");

   a_underrun_kept: assert property (
      st_r.ep[0].underrun && !(wr_lo && sel == 2'h0) |=> st_r.ep[0].underrun)
      else $error("underrun cleared by hardware");

   a_nonempty_read: assert property (
      rd_lo |=> st_r.prdata[`UIEC_LO_NONEMPTY] == $past(sel_nonempty))
      else $error("nonempty bit wrong");

   a_dbuf_release: assert property (
      wr_lo && pwdata[`UIEC_LO_LOADED] && !pwdata[`UIEC_LO_FLUSH] && st_r.ep[sel].double_buffer_on &&
      st_r.ep[sel].cnt == 2'h0 && !link_i.tx_done && !link_i.in_token
      |=> !st_r.ep[$past(sel)].loaded && st_r.ep[$past(sel)].cnt == 2'h1 && st_r.irq == 3'h0)
      else $error("double buffer slot not released");

   a_sent_clears: assert property (
      link_i.tx_done && link_i.token_ep == 2'h1 && st_r.ep[0].cnt != 2'h0 &&
      !st_r.ep[0].held && !wr_take
      |=> !st_r.ep[0].loaded && st_r.irq[0])
      else $error("sent packet not retired");

   a_flush_event: assert property (
      wr_lo && pwdata[`UIEC_LO_FLUSH] && !pwdata[`UIEC_LO_LOADED] && sel_nonempty && !link_i.tx_done
      |=> st_r.irq[$past(sel)] && st_r.ep[$past(sel)].cnt == $past(st_r.ep[sel].cnt) - 2'h1)
      else $error("flush did not drop a packet");

   c_stall: cover property (st_r.resp.valid && st_r.resp.kind == uiec_pkg::RK_STALL);
   c_two_queued: cover property (st_r.ep[0].cnt == 2'h2);
   c_iso_zlp: cover property (st_r.resp.valid && st_r.resp.kind == uiec_pkg::RK_ZLP);
endmodule  // uiec_top

// ### include/uiec_consts.svh
// constants for the low IN endpoint control block
// What this block does
// - writing toggle_clear resets the selected data toggle; it reads zero
// - every STALL handshake sent sets stall_sent_flag
// - while force_stall is one, IN tokens get STALL
// - clearing force_stall returns the endpoint to normal handshakes
// - isochronous: zero-length reply to an empty IN sets underrun_flag
// - bulk or interrupt: each NAK to an IN sets underrun_flag
// - tx_buffer_has_packet reads one while any packet is queued
// - hardware clears packet_loaded once the packet is transmitted
// - double buffered with a free slot: packet_loaded clears at once
// - iso with deferred update: packet_loaded reads zero until next frame start
// - endpoint event for a sent packet, a STALL handshake or a flush, not for a freed slot
// - top bit reads zero, writes ignored
// - flush of a non-empty buffer raises the endpoint event
// - the index register picks which endpoint the registers show
`ifndef UIEC_CONSTS_SVH
`define UIEC_CONSTS_SVH
`define UIEC_IDX_INDEX   8'h0E
`define UIEC_IDX_CTRL_LO 8'h11
`define UIEC_IDX_CTRL_HI 8'h12
`define UIEC_LO_TOGCLR   6
`define UIEC_LO_STSENT   5
`define UIEC_LO_FSTALL   4
`define UIEC_LO_FLUSH    3
`define UIEC_LO_UNDERRUN_FLAG   2
`define UIEC_LO_NONEMPTY 1
`define UIEC_LO_LOADED   0
`define UIEC_HI_DBUF     7
`define UIEC_HI_ISO      6
`define UIEC_HI_ISO_DEFERRED_UPDATE    0
`define UIEC_RESET_BYTE  8'h00
`define UIEC_SLOTS       2'h2
`endif

// ### include/uiec_pkg.sv
// types for the low IN endpoint control block
package uiec_pkg;
   typedef enum logic [1:0] {RK_DATA, RK_ZLP, RK_NAK, RK_STALL} uiec_kind_e;
   typedef struct packed {
      logic       in_token;
      logic [1:0] token_ep;
      logic       sof;
      logic       tx_done;
      logic       tx_acked;
      logic       fifo_wr;
      logic [1:0] fifo_wr_ep;
   } uiec_link_s;
   typedef struct packed {
      logic       valid;
      uiec_kind_e kind;
      logic       toggle;
      logic [1:0] ep;
   } uiec_resp_s;
   typedef struct packed {
      logic       toggle;
      logic       stall_sent;
      logic       force_stall;
      logic       underrun;
      logic       loaded;
      logic       held;
      logic       double_buffer_on;
      logic       iso;
      logic       iso_deferred_update;
      logic [1:0] cnt;
      logic [1:0] zlp;
      logic       data_seen;
   } uiec_ep_s;
   typedef struct packed {
      uiec_ep_s [2:0] ep;
      logic [1:0]     index;
      logic           pready;
      logic           pslverr;
      logic [31:0]    prdata;
      uiec_resp_s     resp;
      logic [2:0]     irq;
   } uiec_state_s;
endpackage

// ### testbench/uiec_host.sv
// host-side model: IN tokens, frame starts, fifo bytes, handshakes
`timescale 1ns/1ns
module uiec_host (
   input  wire logic                 pclk,
   input  wire uiec_pkg::uiec_resp_s resp_o,
   output uiec_pkg::uiec_link_s      link_i
);
   initial begin
      link_i = '0;
   end
   // ------------------------------
   // host requests
   // ------------------------------
   task automatic token(input logic [1:0] ep, output uiec_pkg::uiec_resp_s r);
      r = '0;
      @(posedge pclk);
      link_i.in_token <= 1'b1;
      link_i.token_ep <= ep;
      @(posedge pclk);
      link_i.in_token <= 1'b0;
      for (int i = 0; i < 4 && r.valid !== 1'b1; i++) begin
         @(posedge pclk);
         if (resp_o.valid === 1'b1) begin
            r = resp_o;
         end
      end
   endtask
   // a missed ack retires the packet but leaves the data toggle alone
   task automatic done(input logic [1:0] ep, input logic ack);
      @(posedge pclk);
      link_i.tx_done <= 1'b1;
      link_i.tx_acked <= ack;
      link_i.token_ep <= ep;
      @(posedge pclk);
      link_i.tx_done <= 1'b0;
      link_i.tx_acked <= 1'b0;
   endtask
   task automatic sof();
      @(posedge pclk);
      link_i.sof <= 1'b1;
      @(posedge pclk);
      link_i.sof <= 1'b0;
   endtask
   // released endpoint field shows the inverse, never a stale value
   task automatic fifo_byte(input logic [1:0] ep);
      @(posedge pclk);
      link_i.fifo_wr <= 1'b1;
      link_i.fifo_wr_ep <= ep;
      @(posedge pclk);
      link_i.fifo_wr <= 1'b0;
      link_i.fifo_wr_ep <= ~ep;
   endtask
endmodule // uiec_host

// ### testbench/uiec_top_tb.sv
// self-checking bench for the low IN endpoint control block
`timescale 1ns/1ns
module uiec_top_tb;
   // ------------------------------
   // signals
   // ------------------------------
   localparam logic [7:0] A_IDX = 8'h38;
   localparam logic [7:0] A_LO  = 8'h44;
   localparam logic [7:0] A_HI  = 8'h48;
   logic                 pclk;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [7:0]           paddr;
   logic [31:0]          pwdata;
   logic                 pready;
   logic                 pslverr;
   logic [31:0]          prdata;
   uiec_pkg::uiec_link_s link_i;
   uiec_pkg::uiec_resp_s resp_o;
   logic [2:0]           ep_event;
   uiec_pkg::uiec_resp_s r;
   logic [31:0]          rdat;
   logic                 rerr;
   int                   n_fail;
   int                   n_tests;
   int                   n_ev;

   uiec_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .link_i(link_i), .resp_o(resp_o), .ep_event(ep_event));
   uiec_host i_host (.pclk(pclk), .resp_o(resp_o), .link_i(link_i));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (ep_event[0] === 1'b1) n_ev <= n_ev + 1;
   end
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_resp(input uiec_pkg::uiec_kind_e k, input logic t);
      chk({28'h0, r.valid, r.kind, r.toggle}, {28'h0, 1'b1, k, t}, "handshake");
   endtask
   // no fixed latency assumed: wait for pready, bounded
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED t=%0t no pready", $time);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic lo_is(input logic [7:0] e);
      apb(1'b0, A_LO, 32'h0);
      chk(rdat, {24'h0, e}, "ctrl low");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ------------------------------
   // sequence
   // ------------------------------
   initial begin
      #(40 * 4000);
      n_fail++;
      summarize;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_fail = 0;
      n_tests = 0;
      n_ev = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, A_IDX, 32'h1);
      lo_is(8'h00);
      apb(1'b1, A_LO, 32'h80);
      lo_is(8'h00);
      i_host.token(2'h1, r);
      chk_resp(uiec_pkg::RK_NAK, 1'b0);
      lo_is(8'h04);
      apb(1'b1, A_IDX, 32'h2);
      lo_is(8'h00);
      i_host.token(2'h2, r);
      chk_resp(uiec_pkg::RK_NAK, 1'b0);
      lo_is(8'h04);
      apb(1'b1, A_IDX, 32'h1);
      lo_is(8'h04);
      apb(1'b0, 8'hFC, 32'h0);
      chk({31'h0, rerr}, 32'h1, "unmapped");
      apb(1'b1, A_LO, 32'h00);
      apb(1'b1, A_LO, 32'h01);
      lo_is(8'h03);
      i_host.token(2'h1, r);
      chk_resp(uiec_pkg::RK_ZLP, 1'b0);
      i_host.done(2'h1, 1'b1);
      lo_is(8'h00);
      chk(n_ev, 32'h1, "sent event");
      apb(1'b1, A_LO, 32'h40);
      lo_is(8'h00);
      i_host.fifo_byte(2'h1);
      apb(1'b1, A_LO, 32'h01);
      i_host.token(2'h1, r);
      chk_resp(uiec_pkg::RK_DATA, 1'b0);
      i_host.done(2'h1, 1'b1);
      apb(1'b1, A_LO, 32'h10);
      i_host.token(2'h1, r);
      chk_resp(uiec_pkg::RK_STALL, 1'b1);
      lo_is(8'h30);
      chk(n_ev, 32'h3, "stall event");
      apb(1'b1, A_LO, 32'h00);
      i_host.token(2'h1, r);
      chk_resp(uiec_pkg::RK_NAK, 1'b1);
      lo_is(8'h04);
      apb(1'b1, A_LO, 32'h00);
      i_host.fifo_byte(2'h1);
      apb(1'b1, A_LO, 32'h01);
      apb(1'b1, A_LO, 32'h08);
      lo_is(8'h00);
      chk(n_ev, 32'h4, "flush event");
      apb(1'b1, A_HI, 32'h80);
      i_host.fifo_byte(2'h1);
      apb(1'b1, A_LO, 32'h01);
      lo_is(8'h02);
      chk(n_ev, 32'h4, "no slot event");
      i_host.fifo_byte(2'h1);
      apb(1'b1, A_LO, 32'h01);
      lo_is(8'h03);
      apb(1'b1, A_LO, 32'h08);
      lo_is(8'h02);
      apb(1'b1, A_LO, 32'h08);
      lo_is(8'h00);
      apb(1'b1, A_HI, 32'h41);
      apb(1'b1, A_LO, 32'h01);
      lo_is(8'h02);
      i_host.token(2'h1, r);
      chk({30'h0, r.kind}, {30'h0, uiec_pkg::RK_ZLP}, "iso empty");
      lo_is(8'h06);
      i_host.sof();
      i_host.token(2'h1, r);
      chk({30'h0, r.kind}, {30'h0, uiec_pkg::RK_ZLP}, "iso sent");
      i_host.done(2'h1, 1'b0);
      i_host.token(2'h1, r);
      chk_resp(uiec_pkg::RK_ZLP, 1'b1);
      lo_is(8'h04);
      summarize;
   end
endmodule // uiec_top_tb
